/* hdl/hotplug_params.svh */
`ifndef HOTPLUG_PARAMS_SVH
`define HOTPLUG_PARAMS_SVH
`define DET_NONE 4'h0
`define DET_PRESENT 4'h1
`define DET_ESTABLISHED 4'h3
`define SLOT_COUNT 32
`endif

/* hdl/hotplug_pkg.sv */
package hotplug_pkg;
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_RESET_SENT = 2'b01,
    LINK_NEGOTIATE = 2'b10,
    LINK_UP = 2'b11
  } link_state_t;
  typedef enum logic [1:0] {
    ENG_STOPPED = 2'b00,
    ENG_RUNNING = 2'b01,
    ENG_FATAL = 2'b10
  } engine_state_t;
endpackage : hotplug_pkg

/* hdl/sata_port_hotplug_recovery.sv */
`timescale 1ns/1ps
`include "hotplug_params.svh"
module sata_port_hotplug_recovery
  import hotplug_pkg::*;
#(
  parameter int SLOTS = `SLOT_COUNT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Out-of-band link events from the PHY, one-cycle pulses in the clk domain, except the link up pin, an asynchronous level.
  input wire logic cominitRx,
  input wire logic negotiationDone,
  input wire logic phyLinkUpPin,
  output logic comresetTx,
  output logic startNegotiation,
  output logic wakeLink,
  // Link power state and wake events.
  input wire logic linkLowPower,
  input wire logic powerMgmtEvent,
  // Board presence pins.
  input wire logic coldPresencePin,
  input wire logic mechSwitchPin,
  // Software controls.
  input wire logic port_start,
  input wire logic softwareComreset,
  input wire logic diagExchangedClear,
  input wire logic diagPhyChangeClear,
  input wire logic coldPresenceClear,
  input wire logic mechSwitchClear,
  input wire logic fatalClear,
  input wire logic cold_presence_irq_enable,
  input wire logic global_irq_enable,
  input wire logic fatalEvent,
  input wire logic [SLOTS-1:0] issueSet,
  input wire logic [SLOTS-1:0] activeSet,
  input wire logic [SLOTS-1:0] slotDone,
  // Status toward software.
  output logic [3:0] link_detect_state,
  output logic diag_exchanged_flag,
  output logic diag_phy_change_flag,
  output logic port_connect_change_flag,
  output logic phy_ready_change_flag,
  output logic cold_presence_change_flag,
  output logic cold_presence_state,
  output logic mech_switch_change_flag,
  output logic interface_fatal_flag,
  output logic list_running,
  output logic [SLOTS-1:0] command_issue_vector,
  output logic [SLOTS-1:0] queued_active_vector,
  output logic [$clog2(SLOTS)-1:0] current_slot,
  output logic transferEnable,
  output logic irqRequest
);

  // The slot index and the vectors are sized for at most thirty-two slots.
  if (SLOTS < 2 || SLOTS > 32) begin : g_slots_check
    $error("SLOTS must lie between 2 and 32");
  end

  // Pin synchronisers: three stages, a change counts once stages two and three agree.
  // Only stage two reads stage one, because stage one may still be settling.
  logic [2:0] phySync;
  logic [2:0] coldSync;
  logic [2:0] mechSync;
  logic phyLinkUp;
  logic phyStable;
  logic coldStable;
  logic mechStable;

  always_ff @(posedge clk) begin
    if (reset) begin
      phySync <= 3'h0;
      coldSync <= 3'h0;
      mechSync <= 3'h0;
    end else begin
      phySync <= {phySync[1:0], phyLinkUpPin};
      coldSync <= {coldSync[1:0], coldPresencePin};
      mechSync <= {mechSync[1:0], mechSwitchPin};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phyStable <= 1'b0;
      coldStable <= 1'b0;
      mechStable <= 1'b0;
    end else begin
      if (phySync[1] == phySync[2]) phyStable <= phySync[2];
      if (coldSync[1] == coldSync[2]) coldStable <= coldSync[2];
      if (mechSync[1] == mechSync[2]) mechStable <= mechSync[2];
    end
  end

  assign phyLinkUp = phyStable;
  // Edge detectors reset low, the idle level of the pins, so reset makes no false edge.
  logic phyPrev;
  logic coldPrev;
  logic phyChange;
  logic phyFall;
  logic coldChange;

  always_ff @(posedge clk) begin
    if (reset) begin
      phyPrev <= 1'b0;
      coldPrev <= 1'b0;
    end else begin
      phyPrev <= phyStable;
      coldPrev <= coldStable;
    end
  end

  assign phyChange = phyPrev != phyStable;
  assign phyFall = phyPrev && !phyStable;
  assign coldChange = coldPrev != coldStable;
  assign cold_presence_state = coldStable;

  // Link state: tracks whether a COMINIT was solicited by our own COMRESET.
  link_state_t linkState;
  logic unsolicited;
  logic sendReset;

  // A COMINIT is solicited only while a COMRESET of ours is awaiting its answer.
  assign unsolicited = cominitRx && (linkState != LINK_RESET_SENT);
  assign sendReset = unsolicited || softwareComreset;

  always_ff @(posedge clk) begin
    if (reset) begin
      linkState <= LINK_IDLE;
    end else begin
      case (linkState)
        LINK_IDLE: begin
          if (sendReset) linkState <= LINK_RESET_SENT;
        end
        LINK_RESET_SENT: begin
          // A second COMRESET restarts the wait for the answer of the device.
          if (softwareComreset) linkState <= LINK_RESET_SENT;
          else if (cominitRx) linkState <= LINK_NEGOTIATE;
        end
        LINK_NEGOTIATE: begin
          if (sendReset) linkState <= LINK_RESET_SENT;
          else if (negotiationDone && phyLinkUp) linkState <= LINK_UP;
        end
        LINK_UP: begin
          if (sendReset) linkState <= LINK_RESET_SENT;
          else if (phyFall) linkState <= LINK_IDLE;
        end
        default: linkState <= LINK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      comresetTx <= 1'b0;
      startNegotiation <= 1'b0;
      wakeLink <= 1'b0;
    end else begin
      comresetTx <= sendReset;
      startNegotiation <= cominitRx && (linkState == LINK_RESET_SENT) && !softwareComreset;
      // A wake is only asked for while the link sits in partial or slumber.
      wakeLink <= powerMgmtEvent && linkLowPower;
    end
  end

  // Link detect state; a reset sent this cycle outranks a COMINIT seen with it.
  always_ff @(posedge clk) begin
    if (reset) begin
      link_detect_state <= `DET_NONE;
    end else if (sendReset) begin
      link_detect_state <= `DET_NONE;
    end else if (cominitRx) begin
      link_detect_state <= `DET_PRESENT;
    end else if (linkState == LINK_NEGOTIATE && negotiationDone && phyLinkUp) begin
      link_detect_state <= `DET_ESTABLISHED;
    end else if (phyFall) begin
      link_detect_state <= `DET_PRESENT;
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins.
  always_ff @(posedge clk) begin
    if (reset) begin
      diag_exchanged_flag <= 1'b0;
      diag_phy_change_flag <= 1'b0;
      cold_presence_change_flag <= 1'b0;
      mech_switch_change_flag <= 1'b0;
      interface_fatal_flag <= 1'b0;
    end else begin
      diag_exchanged_flag <= cominitRx || (diag_exchanged_flag && !diagExchangedClear);
      diag_phy_change_flag <= phyChange || (diag_phy_change_flag && !diagPhyChangeClear);
      cold_presence_change_flag <= coldChange ||
        (cold_presence_change_flag && !coldPresenceClear);
      // The mechanical flag follows the level, so it keeps setting while the line is high.
      mech_switch_change_flag <= mechStable ||
        (mech_switch_change_flag && !mechSwitchClear);
      interface_fatal_flag <= fatalEvent || (interface_fatal_flag && !fatalClear);
    end
  end

  // The change flags carry no storage of their own, so they clear with the diagnostic bits.
  assign port_connect_change_flag = diag_exchanged_flag;
  assign phy_ready_change_flag = diag_phy_change_flag;
  // The interrupt is a level that drops once the flag or an enable is cleared.
  assign irqRequest = cold_presence_change_flag && cold_presence_irq_enable &&
    global_irq_enable;

  // Command engine.
  engine_state_t engState;
  logic haltRequest;
  // Every COMINIT sets the connect change flag, so the engine stops on the COMINIT itself.
  assign haltRequest = port_connect_change_flag || cominitRx;

  always_ff @(posedge clk) begin
    if (reset) begin
      engState <= ENG_STOPPED;
    end else begin
      case (engState)
        ENG_STOPPED: begin
          if (port_start && fatalEvent) begin
            engState <= ENG_FATAL;
          end else if (port_start && !haltRequest && !interface_fatal_flag) begin
            engState <= ENG_RUNNING;
          end
        end
        ENG_RUNNING: begin
          // A fatal event outranks a halt, so the restart still needs port start toggled.
          if (!port_start) engState <= ENG_STOPPED;
          else if (fatalEvent) engState <= ENG_FATAL;
          else if (haltRequest) engState <= ENG_STOPPED;
        end
        ENG_FATAL: begin
          if (!port_start) engState <= ENG_STOPPED;
        end
        default: engState <= ENG_STOPPED;
      endcase
    end
  end

  // A halted port stays stopped while its flags stand; a fatal stop also needs start toggled.
  assign list_running = engState == ENG_RUNNING;
  assign transferEnable = list_running && !haltRequest;

  // Vectors reset on port start low; a connect change halt leaves them readable.
  // A slot completed and issued in one cycle stays issued, so no new issue is lost.
  always_ff @(posedge clk) begin
    if (reset) begin
      command_issue_vector <= '0;
      queued_active_vector <= '0;
    end else if (!port_start) begin
      command_issue_vector <= '0;
      queued_active_vector <= '0;
    end else begin
      command_issue_vector <= (command_issue_vector & ~slotDone) | issueSet;
      queued_active_vector <= (queued_active_vector & ~slotDone) | activeSet;
    end
  end

  // Current slot advances to the lowest outstanding slot while running.
  // Slot zero shows until a command is seen, so read it together with the issue vector.
  logic [$clog2(SLOTS)-1:0] nextSlot;
  always_comb begin
    nextSlot = current_slot;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (command_issue_vector[i]) nextSlot = i[$clog2(SLOTS)-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      current_slot <= '0;
    end else if (transferEnable) begin
      current_slot <= nextSlot;
    end
  end

endmodule : sata_port_hotplug_recovery

/* test/hotplug_props.sv */
`timescale 1ns/1ps
module hotplug_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Link events.
  input wire logic cominitRx,
  input wire logic comresetTx,
  input wire logic startNegotiation,
  // Status and controls.
  input wire logic [3:0] link_detect_state,
  input wire logic diag_exchanged_flag,
  input wire logic port_connect_change_flag,
  input wire logic diag_phy_change_flag,
  input wire logic phy_ready_change_flag,
  input wire logic cold_presence_change_flag,
  input wire logic cold_presence_irq_enable,
  input wire logic global_irq_enable,
  input wire logic irqRequest,
  input wire logic list_running,
  input wire logic transferEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_exchange;
    ##1 diag_exchanged_flag && port_connect_change_flag;
  endsequence
  property p_mirror_x; port_connect_change_flag == diag_exchanged_flag; endproperty
  property p_mirror_n; phy_ready_change_flag == diag_phy_change_flag; endproperty
  property p_irq;
    irqRequest == (cold_presence_change_flag && cold_presence_irq_enable && global_irq_enable);
  endproperty
  property p_det_reset; comresetTx |-> link_detect_state == 4'h0; endproperty
  property p_cominit_flag; cominitRx |-> s_exchange; endproperty
  property p_halt; port_connect_change_flag |-> !list_running && !transferEnable; endproperty
  property p_det_nego; startNegotiation |-> link_detect_state == 4'h1; endproperty
  property p_x_cause; $rose(diag_exchanged_flag) |-> $past(cominitRx); endproperty
  a_mirror_x: assert property (p_mirror_x) else $error("connect flag differs");
  a_mirror_n: assert property (p_mirror_n) else $error("phy flag differs");
  a_irq: assert property (p_irq) else $error("interrupt wrong");
  a_det_reset: assert property (p_det_reset) else $error("state not zero");
  a_cominit_flag: assert property (p_cominit_flag) else $error("exchange not set");
  a_halt: assert property (p_halt) else $error("engine not halted");
  a_det_nego: assert property (p_det_nego) else $error("state not one");
  a_x_cause: assert property (p_x_cause) else $error("exchange set alone");
endmodule : hotplug_props
bind sata_port_hotplug_recovery hotplug_props u_hotplug_props (.clk, .reset, .cominitRx,
  .comresetTx, .startNegotiation, .link_detect_state, .diag_exchanged_flag,
  .port_connect_change_flag, .diag_phy_change_flag, .phy_ready_change_flag,
  .cold_presence_change_flag, .cold_presence_irq_enable, .global_irq_enable, .irqRequest,
  .list_running, .transferEnable);

/* test/sata_device_model.sv */
`timescale 1ns/1ps
module sata_device_model (
  // Link toward the port.
  input wire logic clk,
  input wire logic comresetTx,
  input wire logic startNegotiation,
  output logic cominitRx,
  output logic negotiationDone,
  output logic phyUp,
  // Test controls.
  input wire logic plug,
  input wire logic unplug
);
  logic [3:0] rstDly = 4'h0;
  logic [7:0] negDly = 8'h00;
  initial {cominitRx, negotiationDone, phyUp} = 3'b000;
  // The answer lags the reset, so the port must wait for it rather than assume it.
  always @(posedge clk) begin
    rstDly <= {rstDly[2:0], comresetTx};
    negDly <= {negDly[6:0], startNegotiation};
    cominitRx <= plug || rstDly[3];
    negotiationDone <= negDly[7];
    if (startNegotiation) phyUp <= 1'b1;
    if (unplug) phyUp <= 1'b0;
  end
endmodule : sata_device_model

/* test/sata_port_hotplug_recovery_test.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
`define WAIT(c) repeat (20) if (!(c)) @(negedge clk);
module sata_port_hotplug_recovery_test;
  logic clk = 0, reset = 1, port_start = 0, diagExchangedClear = 0, coldPresenceClear = 0;
  logic cold_presence_irq_enable = 0, global_irq_enable = 0, fatalEvent = 0, linkLowPower = 0;
  logic powerMgmtEvent = 0, coldPresencePin = 0, mechSwitchPin = 0, plug = 0, unplug = 0;
  logic softwareComreset = 0, diagPhyChangeClear = 0, fatalClear = 0, transferEnable;
  logic [4:0] current_slot;
  logic [31:0] issueSet = 0, activeSet = 0, command_issue_vector, queued_active_vector;
  logic cominitRx, negotiationDone, phyLinkUpPin, comresetTx, startNegotiation, wakeLink;
  logic diag_exchanged_flag, diag_phy_change_flag, port_connect_change_flag, irqRequest;
  logic phy_ready_change_flag, cold_presence_change_flag, cold_presence_state, list_running;
  logic mech_switch_change_flag, interface_fatal_flag;
  logic [3:0] link_detect_state;
  logic [2:0] rows [4] = '{3'b000, 3'b100, 3'b010, 3'b111};
  int err_count = 0, samples_checked = 0, cycles = 0;
  always #50 clk = ~clk;
  sata_port_hotplug_recovery u_sata_port_hotplug_recovery (.clk, .reset, .cominitRx,
    .negotiationDone, .phyLinkUpPin, .comresetTx, .startNegotiation, .wakeLink,
    .linkLowPower, .powerMgmtEvent, .coldPresencePin, .mechSwitchPin, .port_start,
    .softwareComreset, .diagExchangedClear, .diagPhyChangeClear,
    .coldPresenceClear, .mechSwitchClear(1'b0), .fatalClear, .cold_presence_irq_enable,
    .global_irq_enable, .fatalEvent, .issueSet, .activeSet, .slotDone(32'h0000_0000),
    .link_detect_state, .diag_exchanged_flag, .diag_phy_change_flag,
    .port_connect_change_flag, .phy_ready_change_flag, .cold_presence_change_flag,
    .cold_presence_state, .mech_switch_change_flag, .interface_fatal_flag, .list_running,
    .command_issue_vector, .queued_active_vector, .current_slot, .transferEnable,
    .irqRequest);
  sata_device_model u_sata_device_model (.clk, .comresetTx, .startNegotiation, .cominitRx,
    .negotiationDone, .phyUp(phyLinkUpPin), .plug, .unplug);
  task final_report;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      final_report;
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    reset = 0;
    foreach (rows[i]) begin
      {cold_presence_irq_enable, global_irq_enable} = rows[i][2:1];
      coldPresencePin = ~coldPresencePin;
      repeat (8) @(negedge clk);
      `CHK(cold_presence_change_flag, 1'b1)
      `CHK(cold_presence_state, coldPresencePin)
      `CHK(irqRequest, rows[i][0])
      coldPresenceClear = 1;
      @(negedge clk) coldPresenceClear = 0;
    end
    $display("presence table done");
    port_start = 1;
    issueSet = 32'h0000_000c;
    activeSet = 32'h0000_0002;
    @(negedge clk) {issueSet, activeSet} = 0;
    plug = 1;
    @(negedge clk) plug = 0;
    `WAIT(comresetTx)
    `CHK(comresetTx, 1'b1)
    `CHK(link_detect_state, 4'h0)
    @(negedge clk);
    `CHK(port_connect_change_flag, 1'b1)
    `CHK({list_running, transferEnable}, 2'b00)
    `CHK(command_issue_vector, 32'h0000_000c)
    `CHK(current_slot, 5'h02)
    `WAIT(startNegotiation)
    `CHK(startNegotiation, 1'b1)
    `CHK(link_detect_state, 4'h1)
    `WAIT(link_detect_state === 4'h3)
    `CHK(link_detect_state, 4'h3)
    `CHK(phy_ready_change_flag, 1'b1)
    diagExchangedClear = 1;
    diagPhyChangeClear = 1;
    @(negedge clk) {diagExchangedClear, diagPhyChangeClear} = 2'b00;
    `CHK({port_connect_change_flag, phy_ready_change_flag}, 2'b00)
    repeat (2) @(negedge clk);
    `CHK(list_running, 1'b1)
    port_start = 0;
    `WAIT(!list_running)
    `CHK({command_issue_vector, queued_active_vector}, 64'h0)
    $display("plug test done");
    unplug = 1;
    mechSwitchPin = 1;
    @(negedge clk) unplug = 0;
    repeat (8) @(negedge clk);
    `CHK(link_detect_state, 4'h1)
    `CHK(phy_ready_change_flag, 1'b1)
    `CHK(mech_switch_change_flag, 1'b1)
    linkLowPower = 1;
    powerMgmtEvent = 1;
    @(negedge clk) powerMgmtEvent = 0;
    `WAIT(wakeLink)
    `CHK(wakeLink, 1'b1)
    port_start = 1;
    @(negedge clk);
    `CHK(list_running, 1'b1)
    fatalEvent = 1;
    @(negedge clk) fatalEvent = 0;
    @(negedge clk);
    `CHK(interface_fatal_flag, 1'b1)
    `CHK(list_running, 1'b0)
    fatalClear = 1;
    @(negedge clk) fatalClear = 0;
    @(negedge clk);
    `CHK(list_running, 1'b0)
    port_start = 0;
    @(negedge clk) port_start = 1;
    @(negedge clk);
    `CHK(list_running, 1'b1)
    softwareComreset = 1;
    @(negedge clk) softwareComreset = 0;
    `CHK({comresetTx, link_detect_state}, 5'h10)
    `WAIT(port_connect_change_flag)
    `CHK({list_running, link_detect_state}, 5'h01)
    `CHK(startNegotiation, 1'b1)
    diagExchangedClear = 1;
    @(negedge clk) diagExchangedClear = 0;
    `CHK(port_connect_change_flag, 1'b0)
    port_start = 0;
    reset = 1;
    @(negedge clk) reset = 0;
    `CHK(link_detect_state, 4'h0)
    `CHK({list_running, port_connect_change_flag, phy_ready_change_flag}, 3'b000)
    @(negedge clk);
    `CHK(interface_fatal_flag, 1'b0)
    $display("unplug test done");
    final_report;
  end
endmodule : sata_port_hotplug_recovery_test
